// File: rtl/rihc_pkg.sv
package rihc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_IO_PTR = 8'h08;
	localparam logic [7:0] OFF_IO_CMD = 8'h0c;
	localparam logic [7:0] OFF_IO_DATA = 8'h10;
	localparam logic [7:0] OFF_VECTOR = 8'h14;
	// Control bits
	localparam int CTRL_IE = 0;
	localparam int CTRL_IRET = 1;
	localparam int CTRL_HALT = 2;
	// I/O command bits
	localparam int CMD_WR = 0;
	localparam int CMD_WORD = 1;
	localparam int CMD_PTR = 2;
	localparam int CMD_PORT_LSB = 8;
	// Status bits
	localparam int STS_IE = 0;
	localparam int STS_HALT = 1;
	localparam int STS_NMI = 2;
	localparam int STS_BUSY = 3;
	localparam int STS_DONE = 4;
	localparam int STS_RUN = 5;
	localparam int STS_MAX = 6;
	localparam int STS_HOLD = 7;
	localparam int STS_SAVED = 8;
	// Timing counts
	localparam int CLK_PERIOD_NS = 10;
	localparam int INIT_CYC = 10;
	localparam int NMI_IGNORE = 2;
	localparam int CNT_W = 4;
	// Addresses and codes
	localparam logic [19:0] BOOT_ADDR = 20'hffff0;
	localparam logic [3:0] IO_PAGE_HI = 4'h0;
	localparam logic [7:0] NMI_TYPE = 8'h02;
	localparam logic [2:0] CS_ACK = 3'h0;
	localparam logic [2:0] CS_IOR = 3'h1;
	localparam logic [2:0] CS_IOW = 3'h2;
	localparam logic [2:0] CS_HALT = 3'h3;
	localparam logic [2:0] CS_PASS = 3'h7;
	localparam logic [1:0] T1 = 2'h0;
	localparam logic [1:0] T2 = 2'h1;
	localparam logic [1:0] T3 = 2'h2;
	localparam logic [1:0] T4 = 2'h3;

	typedef enum logic [2:0] {
		ST_RST = 3'b000,
		ST_INIT = 3'b001,
		ST_IDLE = 3'b010,
		ST_ACK = 3'b011,
		ST_IO = 3'b100,
		ST_HALT = 3'b101,
		ST_HOLD = 3'b110
	} rihc_state_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} rihc_apb_req_type;

	typedef struct packed {
		logic ale;
		logic irq_ack_cycle;
		logic lock;
		logic [2:0] cycle_status_bits;
		logic status_oe;
		logic [19:0] addr;
		logic addr_oe;
		logic lane_hi;
		logic lane_lo;
	} rihc_pins_type;
endpackage : rihc_pkg

// File: rtl/rihc_ctrl.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module rihc_ctrl #(
	parameter int INIT_CYCLES = rihc_pkg::INIT_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic cpu_reset_i,
	input wire logic nmi_i,
	input wire logic maskable_request_i,
	input wire logic hold_req_i,
	input wire logic mode_strap_i,
	input wire logic instr_end_i,
	input wire logic [15:0] data_in_i,
	input rihc_pkg::rihc_apb_req_type apb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output rihc_pkg::rihc_pins_type pins_o,
	output logic [15:0] data_out_o,
	output logic data_oe_o,
	output logic hold_grant_out_o,
	output logic core_run_o,
	output logic [19:0] fetch_addr_o,
	output logic vec_valid_o,
	output logic [9:0] vec_ptr_o,
	output logic [7:0] vec_type_o
);
	rihc_pkg::rihc_state_type st_r;
	rihc_pkg::rihc_pins_type pins_r;
	logic rst_s1_r, rst_s2_r, rst_q_r, rst_first_r;
	logic nmi_s1_r, nmi_s2_r, nmi_q_r, nmi_pend_r;
	logic maskable_request_q_r, ie_r, ie_saved_r, halted_r, max_mode_r;
	logic [rihc_pkg::CNT_W-1:0] init_cnt_r;
	logic [1:0] t_r;
	logic ack2_r, io_go_r, halt_go_r, io_done_r;
	logic io_wr_r, io_word_r, io_ptr_mode_r;
	logic [15:0] io_port_r, io_ptr_r, io_data_r, io_rdata_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r, core_run_r, vec_valid_r, hold_grant_r;
	logic [19:0] fetch_addr_r;
	logic [7:0] vec_type_r;
	logic [15:0] data_out_r;
	logic data_oe_r;
	logic rst_fall, nmi_edge, nmi_ok, wake, take_nmi, take_maskable_request;
	logic init_last, ack_end, apb_setup, apb_wr, hit;
	logic [31:0] rd_mux;

	// Event decode
	assign rst_fall = !rst_s2_r && rst_q_r;
	assign nmi_edge = nmi_s2_r && !nmi_q_r;
	assign init_last = init_cnt_r == rihc_pkg::CNT_W'(INIT_CYCLES - 1);
	assign nmi_ok = !(st_r == rihc_pkg::ST_RST) && !rst_s2_r &&
		!(st_r == rihc_pkg::ST_INIT &&
		init_cnt_r < rihc_pkg::CNT_W'(rihc_pkg::NMI_IGNORE));
	assign wake = (st_r == rihc_pkg::ST_IDLE && instr_end_i) ||
		st_r == rihc_pkg::ST_HALT;
	assign take_nmi = nmi_pend_r && wake && !rst_s2_r;
	assign take_maskable_request = !nmi_pend_r && maskable_request_q_r && ie_r && wake &&
		!rst_s2_r;
	assign ack_end = st_r == rihc_pkg::ST_ACK && ack2_r &&
		t_r == rihc_pkg::T4;

	// Reset input synchroniser and edge history
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= 1'b1;
			rst_q_r <= 1'b1;
		end else begin
			rst_s1_r <= cpu_reset_i;
			rst_s2_r <= rst_s1_r;
			rst_q_r <= rst_s2_r;
		end
	end

	// Marks the first clock of reset
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rst_first_r <= 1'b0;
		end else begin
			rst_first_r <= st_r != rihc_pkg::ST_RST;
		end
	end

	// Mode strap caught as reset is released
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			max_mode_r <= 1'b0;
		end else if (rst_fall) begin
			max_mode_r <= !mode_strap_i;
		end
	end

	// Non-maskable synchroniser and edge latch
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			nmi_s1_r <= 1'b0;
			nmi_s2_r <= 1'b0;
			nmi_q_r <= 1'b0;
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_s1_r <= nmi_i;
			nmi_s2_r <= nmi_s1_r;
			nmi_q_r <= nmi_s2_r;
			if (rst_s2_r) begin
				nmi_pend_r <= 1'b0;
			end else if (nmi_edge && nmi_ok) begin
				nmi_pend_r <= 1'b1;
			end else if (take_nmi) begin
				nmi_pend_r <= 1'b0;
			end
		end
	end

	// Maskable level sampled every clock
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			maskable_request_q_r <= 1'b0;
		end else begin
			maskable_request_q_r <= maskable_request_i;
		end
	end

	// Interrupt enable flag and its pushed copy
	always_ff @(posedge clk_i) begin
		if (srst_i || rst_s2_r) begin
			ie_r <= 1'b0;
			ie_saved_r <= 1'b0;
		end else if (take_nmi || take_maskable_request) begin
			ie_saved_r <= ie_r;
			ie_r <= 1'b0;
		end else if (apb_wr && apb_i.paddr == rihc_pkg::OFF_CTRL) begin
			if (apb_i.pwdata[rihc_pkg::CTRL_IRET]) begin
				ie_r <= ie_saved_r;
			end else begin
				ie_r <= apb_i.pwdata[rihc_pkg::CTRL_IE];
			end
		end
	end

	// Main sequencer
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r <= rihc_pkg::ST_RST;
			t_r <= rihc_pkg::T1;
			ack2_r <= 1'b0;
			init_cnt_r <= '0;
		end else if (rst_s2_r) begin
			st_r <= rihc_pkg::ST_RST;
		end else begin
			unique case (st_r)
			rihc_pkg::ST_RST: begin
				st_r <= rihc_pkg::ST_INIT;
				init_cnt_r <= '0;
			end
			rihc_pkg::ST_INIT: begin
				if (init_last) begin
					if (hold_req_i) begin
						st_r <= rihc_pkg::ST_HOLD;
					end else begin
						st_r <= rihc_pkg::ST_IDLE;
					end
				end else begin
					init_cnt_r <= init_cnt_r + 1'b1;
				end
			end
			rihc_pkg::ST_IDLE: begin
				t_r <= rihc_pkg::T1;
				ack2_r <= 1'b0;
				if (take_nmi) begin
					st_r <= rihc_pkg::ST_IDLE;
				end else if (take_maskable_request) begin
					st_r <= rihc_pkg::ST_ACK;
				end else if (hold_req_i) begin
					st_r <= rihc_pkg::ST_HOLD;
				end else if (io_go_r) begin
					st_r <= rihc_pkg::ST_IO;
				end else if (halt_go_r) begin
					st_r <= rihc_pkg::ST_HALT;
				end
			end
			rihc_pkg::ST_ACK: begin
				t_r <= t_r + 2'h1;
				if (t_r == rihc_pkg::T4) begin
					ack2_r <= 1'b1;
					if (ack2_r) begin
						st_r <= rihc_pkg::ST_IDLE;
					end
				end
			end
			rihc_pkg::ST_IO: begin
				t_r <= t_r + 2'h1;
				if (t_r == rihc_pkg::T4) begin
					st_r <= rihc_pkg::ST_IDLE;
				end
			end
			rihc_pkg::ST_HALT: begin
				if (take_nmi) begin
					st_r <= rihc_pkg::ST_IDLE;
				end else if (take_maskable_request) begin
					st_r <= rihc_pkg::ST_ACK;
					t_r <= rihc_pkg::T1;
					ack2_r <= 1'b0;
				end else if (hold_req_i) begin
					st_r <= rihc_pkg::ST_HOLD;
				end else if (t_r != rihc_pkg::T4) begin
					t_r <= t_r + 2'h1;
				end
			end
			rihc_pkg::ST_HOLD: begin
				t_r <= rihc_pkg::T1;
				if (!hold_req_i) begin
					if (halted_r) begin
						st_r <= rihc_pkg::ST_HALT;
					end else begin
						st_r <= rihc_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				st_r <= rihc_pkg::ST_RST;
			end
			endcase
		end
	end

	// Halt memory survives a hold
	always_ff @(posedge clk_i) begin
		if (srst_i || rst_s2_r) begin
			halted_r <= 1'b0;
		end else if (st_r == rihc_pkg::ST_HALT) begin
			halted_r <= !(take_nmi || take_maskable_request);
		end
	end

	// Software-requested I/O and halt
	always_ff @(posedge clk_i) begin
		if (srst_i || rst_s2_r) begin
			io_go_r <= 1'b0;
			halt_go_r <= 1'b0;
			io_wr_r <= 1'b0;
			io_word_r <= 1'b0;
			io_ptr_mode_r <= 1'b0;
			io_port_r <= 16'h0000;
		end else begin
			if (apb_wr && apb_i.paddr == rihc_pkg::OFF_IO_CMD &&
			    !io_go_r && st_r != rihc_pkg::ST_IO) begin
				io_go_r <= 1'b1;
				io_wr_r <= apb_i.pwdata[rihc_pkg::CMD_WR];
				io_word_r <= apb_i.pwdata[rihc_pkg::CMD_WORD];
				io_ptr_mode_r <= apb_i.pwdata[rihc_pkg::CMD_PTR];
				if (apb_i.pwdata[rihc_pkg::CMD_PTR]) begin
					io_port_r <= io_ptr_r;
				end else begin
					io_port_r <= {8'h00,
						apb_i.pwdata[rihc_pkg::CMD_PORT_LSB +: 8]};
				end
			end else if (st_r == rihc_pkg::ST_IO) begin
				io_go_r <= 1'b0;
			end
			if (apb_wr && apb_i.paddr == rihc_pkg::OFF_CTRL &&
			    apb_i.pwdata[rihc_pkg::CTRL_HALT]) begin
				halt_go_r <= 1'b1;
			end else if (st_r == rihc_pkg::ST_HALT) begin
				halt_go_r <= 1'b0;
			end
		end
	end

	// I/O data, pointer and completion flag
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			io_ptr_r <= 16'h0000;
			io_data_r <= 16'h0000;
			io_rdata_r <= 16'h0000;
			io_done_r <= 1'b0;
		end else begin
			if (apb_wr && apb_i.paddr == rihc_pkg::OFF_IO_PTR) begin
				io_ptr_r <= apb_i.pwdata[15:0];
			end
			if (apb_wr && apb_i.paddr == rihc_pkg::OFF_IO_DATA) begin
				io_data_r <= apb_i.pwdata[15:0];
			end
			if (st_r == rihc_pkg::ST_IO && t_r == rihc_pkg::T4) begin
				io_done_r <= 1'b1;
				if (!io_wr_r) begin
					if (io_word_r) begin
						io_rdata_r <= data_in_i;
					end else if (io_port_r[0]) begin
						io_rdata_r <= {8'h00, data_in_i[15:8]};
					end else begin
						io_rdata_r <= {8'h00, data_in_i[7:0]};
					end
				end
			end else if (apb_wr && apb_i.paddr == rihc_pkg::OFF_STATUS &&
			             apb_i.pwdata[rihc_pkg::STS_DONE]) begin
				io_done_r <= 1'b0;
			end
		end
	end

	// Vector output and start address
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			vec_valid_r <= 1'b0;
			vec_type_r <= 8'h00;
			fetch_addr_r <= 20'h00000;
			core_run_r <= 1'b0;
		end else begin
			vec_valid_r <= take_nmi || ack_end;
			if (take_nmi) begin
				vec_type_r <= rihc_pkg::NMI_TYPE;
			end else if (ack_end) begin
				vec_type_r <= data_in_i[7:0];
			end
			if (st_r == rihc_pkg::ST_INIT && init_last) begin
				fetch_addr_r <= rihc_pkg::BOOT_ADDR;
			end
			core_run_r <= st_r == rihc_pkg::ST_IDLE && !rst_s2_r;
		end
	end

	// Bus pins, one clock behind the sequencer
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pins_r <= '0;
			pins_r.cycle_status_bits <= rihc_pkg::CS_PASS;
			hold_grant_r <= 1'b0;
			data_oe_r <= 1'b0;
			data_out_r <= 16'h0000;
		end else begin
			pins_r.ale <= !max_mode_r && t_r == rihc_pkg::T1 &&
				(st_r == rihc_pkg::ST_ACK || st_r == rihc_pkg::ST_IO ||
				st_r == rihc_pkg::ST_HALT);
			pins_r.irq_ack_cycle <= !max_mode_r &&
				st_r == rihc_pkg::ST_ACK &&
				(t_r == rihc_pkg::T2 || t_r == rihc_pkg::T3);
			pins_r.lock <= st_r == rihc_pkg::ST_ACK &&
				((!ack2_r && t_r != rihc_pkg::T1) ||
				(ack2_r && t_r == rihc_pkg::T1));
			pins_r.cycle_status_bits <= rihc_pkg::CS_PASS;
			if (max_mode_r && t_r != rihc_pkg::T4) begin
				unique case (st_r)
				rihc_pkg::ST_ACK: pins_r.cycle_status_bits <= rihc_pkg::CS_ACK;
				rihc_pkg::ST_IO: pins_r.cycle_status_bits <=
					io_wr_r ? rihc_pkg::CS_IOW : rihc_pkg::CS_IOR;
				rihc_pkg::ST_HALT: pins_r.cycle_status_bits <=
					rihc_pkg::CS_HALT;
				default: pins_r.cycle_status_bits <= rihc_pkg::CS_PASS;
				endcase
			end
			pins_r.status_oe <= st_r != rihc_pkg::ST_HOLD &&
				!(st_r == rihc_pkg::ST_RST && !rst_first_r);
			pins_r.addr <= {rihc_pkg::IO_PAGE_HI, io_port_r};
			pins_r.addr_oe <= st_r == rihc_pkg::ST_IO;
			pins_r.lane_lo <= io_word_r || !io_port_r[0];
			pins_r.lane_hi <= io_word_r || io_port_r[0];
			hold_grant_r <= st_r == rihc_pkg::ST_HOLD;
			data_oe_r <= st_r == rihc_pkg::ST_IO && io_wr_r &&
				t_r != rihc_pkg::T1;
			if (io_word_r) begin
				data_out_r <= io_data_r;
			end else if (io_port_r[0]) begin
				data_out_r <= {io_data_r[7:0], 8'h00};
			end else begin
				data_out_r <= {8'h00, io_data_r[7:0]};
			end
		end
	end

	// APB decode, zero-wait slave with registered answer
	assign apb_setup = apb_i.psel && !apb_i.penable;
	assign apb_wr = apb_i.psel && apb_i.penable && pready_r && apb_i.pwrite;
	assign hit = apb_i.paddr == rihc_pkg::OFF_CTRL ||
		apb_i.paddr == rihc_pkg::OFF_STATUS ||
		apb_i.paddr == rihc_pkg::OFF_IO_PTR ||
		apb_i.paddr == rihc_pkg::OFF_IO_CMD ||
		apb_i.paddr == rihc_pkg::OFF_IO_DATA ||
		apb_i.paddr == rihc_pkg::OFF_VECTOR;

	// Read data selection
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (apb_i.paddr)
		rihc_pkg::OFF_CTRL: rd_mux[rihc_pkg::CTRL_IE] = ie_r;
		rihc_pkg::OFF_STATUS: begin
			rd_mux[rihc_pkg::STS_IE] = ie_r;
			rd_mux[rihc_pkg::STS_HALT] = halted_r;
			rd_mux[rihc_pkg::STS_NMI] = nmi_pend_r;
			rd_mux[rihc_pkg::STS_BUSY] = io_go_r || st_r == rihc_pkg::ST_IO;
			rd_mux[rihc_pkg::STS_DONE] = io_done_r;
			rd_mux[rihc_pkg::STS_RUN] = core_run_r;
			rd_mux[rihc_pkg::STS_MAX] = max_mode_r;
			rd_mux[rihc_pkg::STS_HOLD] = hold_grant_r;
			rd_mux[rihc_pkg::STS_SAVED] = ie_saved_r;
		end
		rihc_pkg::OFF_IO_PTR: rd_mux[15:0] = io_ptr_r;
		rihc_pkg::OFF_IO_DATA: rd_mux[15:0] = io_rdata_r;
		rihc_pkg::OFF_VECTOR: rd_mux[17:0] = {vec_type_r, vec_type_r, 2'h0};
		default: rd_mux = 32'h00000000;
		endcase
	end

	// Answer flops
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= apb_setup;
			pslverr_r <= apb_setup && !hit;
			if (apb_setup && !apb_i.pwrite) begin
				prdata_r <= rd_mux;
			end
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign pins_o = pins_r;
	assign data_out_o = data_out_r;
	assign data_oe_o = data_oe_r;
	assign hold_grant_out_o = hold_grant_r;
	assign core_run_o = core_run_r;
	assign fetch_addr_o = fetch_addr_r;
	assign vec_valid_o = vec_valid_r;
	assign vec_ptr_o = {vec_type_r, 2'h0};
	assign vec_type_o = vec_type_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_ack_start;
		st_r != rihc_pkg::ST_ACK ##1 st_r == rihc_pkg::ST_ACK;
	endsequence

	a_io_page_zero: assert property (pins_r.addr_oe |->
		pins_r.addr[19:16] == 4'h0) else $error("io high address");
	a_direct_page: assert property (st_r == rihc_pkg::ST_IO &&
		!io_ptr_mode_r |-> io_port_r[15:8] == 8'h00)
		else $error("direct io off page");
	a_byte_lane: assert property (pins_r.addr_oe && !io_word_r |->
		pins_r.lane_hi == pins_r.addr[0] &&
		pins_r.lane_lo == !pins_r.addr[0]) else $error("byte lane");
	a_reset_dormant: assert property (st_r == rihc_pkg::ST_RST |=>
		!core_run_o && !pins_r.ale) else $error("active in reset");
	a_init_length: assert property (st_r == rihc_pkg::ST_RST &&
		rst_fall |=> (st_r == rihc_pkg::ST_INIT)[*8] ##1
		st_r == rihc_pkg::ST_INIT ##1 st_r == rihc_pkg::ST_INIT ##1
		st_r != rihc_pkg::ST_INIT) else $error("init length");
	a_reset_sync: assert property ($rose(rst_s2_r) |=>
		st_r == rihc_pkg::ST_RST) else $error("reset not taken");
	a_nmi_early: assert property (nmi_edge && st_r == rihc_pkg::ST_INIT &&
		init_cnt_r == 4'h0 && !nmi_pend_r |=> !nmi_pend_r)
		else $error("early nmi kept");
	a_hold_first: assert property (st_r == rihc_pkg::ST_INIT &&
		init_last && hold_req_i |=> st_r == rihc_pkg::ST_HOLD)
		else $error("hold not first");
	a_reset_float: assert property ((st_r == rihc_pkg::ST_RST)[*2] |=>
		!pins_r.status_oe && !pins_r.addr_oe && !hold_grant_out_o)
		else $error("driven in reset");
	a_nmi_type: assert property (take_nmi |=> vec_valid_o &&
		vec_type_o == 8'h02 && vec_ptr_o == 10'h008)
		else $error("nmi type");
	a_nmi_latch: assert property (nmi_edge && nmi_ok |=>
		nmi_pend_r || vec_valid_o) else $error("nmi edge lost");
	a_maskable_request_mask: assert property (!ie_r |-> !take_maskable_request)
		else $error("masked request taken");
	a_ie_clear: assert property (take_nmi || take_maskable_request |=> !ie_r &&
		ie_saved_r == $past(ie_r)) else $error("enable not cleared");
	a_lock_span: assert property (s_ack_start |=> !pins_r.lock ##1
		pins_r.lock[*4] ##1 !pins_r.lock) else $error("lock span");
	a_ack_hold: assert property (st_r == rihc_pkg::ST_ACK |=>
		!hold_grant_out_o) else $error("hold during ack");
	a_ack_type: assert property (ack_end |=> vec_valid_o &&
		vec_ptr_o == {$past(data_in_i[7:0]), 2'h0}) else $error("ack type");
	a_halt_code: assert property (st_r == rihc_pkg::ST_HALT &&
		t_r == rihc_pkg::T1 && max_mode_r |=>
		pins_r.cycle_status_bits == 3'h3) else $error("halt code");
	a_halt_resume: assert property (st_r == rihc_pkg::ST_HOLD &&
		halted_r && !hold_req_i |=> st_r == rihc_pkg::ST_HALT)
		else $error("halt lost");
endmodule : rihc_ctrl

// File: tb/rihc_pic_model.sv
`timescale 1ns/1ns
module rihc_pic_model #(
	parameter logic [7:0] TYPE_BYTE = 8'h5b
) (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic done_i,
	output logic [15:0] data_o
);
	logic ack_q = 1'b0;
	logic [1:0] acks = 2'h0;
	logic [15:0] junk = 16'h0f0f;
	// Count acknowledge cycles; junk keeps the idle bus from looking stable
	always @(posedge clk_i) begin
		ack_q <= ack_i;
		junk <= ~junk;
		if (done_i)
			acks <= 2'h0;
		else if (ack_i && !ack_q && acks != 2'h2)
			acks <= acks + 2'h1;
	end
	// Type byte on the low lane only in the second cycle
	assign data_o = (acks == 2'h2) ? {junk[15:8], TYPE_BYTE} : junk;
endmodule : rihc_pic_model

// File: tb/cpu_reset_interrupt_halt_control_test.sv
`timescale 1ns/1ns
module cpu_reset_interrupt_halt_control_test;
	localparam logic [7:0] TYP = 8'h5b;
	localparam int PWR_UP_CYC = 5000; // 50 us of 10 ns clocks
	logic mstrap = 1'b1;
	logic [15:0] dout;
	logic doe;
	logic hs;
	int ale_n = 0;
	int m;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic cpu_reset_i = 1'b1;
	logic nmi_i = 1'b0;
	logic mreq = 1'b0;
	logic hold_i = 1'b0;
	logic iend = 1'b0;
	logic ack_q = 1'b0;
	logic [15:0] din;
	rihc_pkg::rihc_apb_req_type apb = '0;
	rihc_pkg::rihc_pins_type pins;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic perr;
	logic hgnt;
	logic run;
	logic vv;
	logic io_on;
	logic [19:0] faddr;
	logic [9:0] vptr;
	logic [7:0] vtyp;
	int error_cnt = 0;
	int samples_checked = 0;
	int ack_n = 0;
	int lock_n = 0;
	int vec_n = 0;
	int n;

	always #5 clk_i = ~clk_i;
	always_comb io_on = pins.addr_oe;
	always_comb hs = pins.cycle_status_bits == rihc_pkg::CS_HALT;

	rihc_ctrl #(.INIT_CYCLES(10)) uut (.clk_i(clk_i), .srst_i(srst_i),
		.cpu_reset_i(cpu_reset_i), .nmi_i(nmi_i), .maskable_request_i(mreq),
		.hold_req_i(hold_i), .mode_strap_i(mstrap), .instr_end_i(iend),
		.data_in_i(din), .apb_i(apb), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .pins_o(pins), .data_out_o(dout),
		.data_oe_o(doe),
		.hold_grant_out_o(hgnt), .core_run_o(run), .fetch_addr_o(faddr),
		.vec_valid_o(vv), .vec_ptr_o(vptr), .vec_type_o(vtyp));
	rihc_pic_model #(.TYPE_BYTE(TYP)) pic (.clk_i(clk_i),
		.ack_i(pins.irq_ack_cycle), .done_i(vv), .data_o(din));

	// Count acknowledge cycles, lock clocks and vectors; grant must wait
	always @(posedge clk_i) begin
		ack_q <= pins.irq_ack_cycle;
		if (pins.irq_ack_cycle && !ack_q)
			ack_n++;
		if (pins.lock)
			lock_n++;
		if (vv)
			vec_n++;
		if (pins.ale)
			ale_n++;
		if (hgnt && (pins.lock || pins.irq_ack_cycle)) begin
			error_cnt++;
			$display("BAD %0t grant during acknowledge", $time);
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk

	task summarize;
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	task tmo;
		error_cnt++;
		$display("BAD %0t wait timed out", $time);
		summarize();
	endtask : tmo

	// Wait for a level at a falling edge, where outputs have settled
	task automatic wait_hi(ref logic s);
		int k;
		for (k = 0; k < 300; k++) begin
			@(negedge clk_i);
			if (s === 1'b1)
				break;
		end
		if (k == 300)
			tmo();
	endtask : wait_hi

	// One APB transfer; request held until pready is seen high at a rise
	task automatic apb_x(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk_i);
		apb.psel <= 1'b1;
		apb.pwrite <= w;
		apb.paddr <= a;
		apb.pwdata <= d;
		@(posedge clk_i);
		apb.penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_i);
			if (pready === 1'b1)
				break;
		end
		if (k == 50)
			tmo();
		rd = prdata;
		perr = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask : apb_x

	task pulse;
		@(posedge clk_i);
		iend <= 1'b1;
		@(posedge clk_i);
		iend <= 1'b0;
	endtask : pulse

	initial begin
		// Device reset with an early edge and a hold request at release
		repeat (8) @(posedge clk_i);
		srst_i <= 1'b0;
		nmi_i <= 1'b1;
		repeat (PWR_UP_CYC) @(posedge clk_i);
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		chk({pins.addr_oe, pins.status_oe, pins.ale, hgnt, run}, 0, "float");
		@(posedge clk_i);
		hold_i <= 1'b1;
		cpu_reset_i <= 1'b0;
		wait_hi(hgnt);
		chk(run, 1'b0, "fetch before hold");
		@(posedge clk_i);
		hold_i <= 1'b0;
		nmi_i <= 1'b0;
		wait_hi(run);
		chk(faddr, rihc_pkg::BOOT_ADDR, "boot address");
		apb_x(1'b0, rihc_pkg::OFF_STATUS, 0);
		chk(rd[rihc_pkg::STS_NMI], 1'b0, "early edge kept");
		apb_x(1'b0, 8'h40, 0);
		chk(perr, 1'b1, "unmapped offset");
		// Direct write to an odd port, pointer read of an even port
		apb_x(1'b1, rihc_pkg::OFF_IO_DATA, 32'h0000a5c3);
		apb_x(1'b1, rihc_pkg::OFF_IO_CMD, 32'h00003501);
		wait_hi(io_on);
		chk({pins.addr, pins.lane_hi, pins.lane_lo},
			{rihc_pkg::IO_PAGE_HI, 16'h0035, 2'b10}, "direct io");
		@(negedge clk_i);
		chk({doe, dout}, {1'b1, 16'hc300}, "odd write lane");
		apb_x(1'b1, rihc_pkg::OFF_IO_PTR, 32'h0000bee4);
		apb_x(1'b1, rihc_pkg::OFF_IO_CMD, 32'h00000004);
		wait_hi(io_on);
		chk({pins.addr, pins.lane_hi, pins.lane_lo},
			{rihc_pkg::IO_PAGE_HI, 16'hbee4, 2'b01}, "pointer io");
		// Halt, hold while halted, leave on a non-maskable edge
		apb_x(1'b1, rihc_pkg::OFF_CTRL, 32'h4);
		n = ale_n;
		repeat (3) @(posedge clk_i);
		hold_i <= 1'b1;
		wait_hi(hgnt);
		apb_x(1'b0, rihc_pkg::OFF_STATUS, 0);
		chk(rd[rihc_pkg::STS_HALT], 1'b1, "halt lost in hold");
		hold_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		nmi_i <= 1'b1;
		wait_hi(vv);
		chk({vtyp, vptr}, {rihc_pkg::NMI_TYPE, rihc_pkg::NMI_TYPE, 2'b00},
			"nmi vector");
		chk(ale_n - n, 2, "halt strobes");
		apb_x(1'b0, rihc_pkg::OFF_STATUS, 0);
		chk(rd[rihc_pkg::STS_HALT], 1'b0, "still halted");
		// Request ignored while disabled, then served once enabled
		nmi_i <= 1'b0;
		mreq <= 1'b1;
		n = vec_n;
		pulse();
		repeat (20) @(posedge clk_i);
		chk(vec_n, n, "masked request served");
		apb_x(1'b1, rihc_pkg::OFF_CTRL, 32'h1);
		n = ack_n;
		m = lock_n;
		pulse();
		hold_i <= 1'b1;
		wait_hi(vv);
		chk({vtyp, vptr}, {TYP, TYP, 2'b00}, "vector");
		chk(ack_n - n, 2, "ack cycles");
		chk(lock_n - m, 4, "lock length");
		wait_hi(hgnt);
		@(posedge clk_i);
		hold_i <= 1'b0;
		mreq <= 1'b0;
		apb_x(1'b0, rihc_pkg::OFF_STATUS, 0);
		chk({rd[rihc_pkg::STS_SAVED], rd[rihc_pkg::STS_IE]}, 2'b10,
			"enable after response");
		apb_x(1'b1, rihc_pkg::OFF_CTRL, 32'h2);
		apb_x(1'b0, rihc_pkg::OFF_STATUS, 0);
		chk(rd[rihc_pkg::STS_IE], 1'b1, "enable not restored");
		// Second device reset in mid-run stops everything
		cpu_reset_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		@(negedge clk_i);
		chk({run, pins.addr_oe, hgnt}, 0, "active in reset");
		// Release in maximum mode; edge in first init clock is dropped
		@(posedge clk_i);
		mstrap <= 1'b0;
		cpu_reset_i <= 1'b0;
		@(posedge clk_i);
		nmi_i <= 1'b1;
		wait_hi(run);
		chk(pins.cycle_status_bits, rihc_pkg::CS_PASS, "idle status");
		apb_x(1'b0, rihc_pkg::OFF_STATUS, 0);
		chk({rd[rihc_pkg::STS_MAX], rd[rihc_pkg::STS_NMI]}, 2'b10,
			"max mode");
		nmi_i <= 1'b0;
		apb_x(1'b1, rihc_pkg::OFF_CTRL, 32'h4);
		wait_hi(hs);
		chk(pins.ale, 1'b0, "strobe in max halt");
		@(posedge clk_i);
		nmi_i <= 1'b1;
		wait_hi(vv);
		chk(vtyp, rihc_pkg::NMI_TYPE, "max halt exit");
		summarize();
	end
endmodule : cpu_reset_interrupt_halt_control_test
